/* inc/psb_pkg.sv */
// Shared constants for the processor system bus ends
package psb_pkg;
  localparam int AD_W = 32;
  localparam int CMD_W = 9;
  localparam int CMD_LEG_W = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int CPU_WORD_W = 1 + CMD_W + AD_W;
  localparam int AGT_WORD_W = CMD_W + AD_W;
  localparam logic MODE_LEGACY = 1'b0;
  localparam logic MODE_EXTENDED = 1'b1;
  localparam logic PIN_ASSERT = 1'b0;
  localparam logic PIN_IDLE = 1'b1;
  localparam logic [CMD_W-1:0] CMD_OE_ALL = 9'h1ff;
  localparam logic [CMD_W-1:0] CMD_OE_LEG = 9'h01f;
  localparam logic [CMD_W-1:0] CMD_OE_NONE = 9'h000;
  localparam logic [CMD_W-1:0] CMD_GND_LEG = 9'h1e0;
  localparam logic [AD_W-1:0] AD_ZERO = 32'h0000_0000;
  localparam logic [CMD_W-1:0] CMD_ZERO = 9'h000;
  typedef enum logic [1:0] {
    PSB_ST_MASTER = 2'b00,
    PSB_ST_YIELD = 2'b01,
    PSB_ST_SLAVE = 2'b10
  } psb_state_t;
endpackage : psb_pkg

/* inc/psb_bus_if.sv */
// Pin bundle joining the processor end and the agent end
`timescale 1ns/1ps
`default_nettype none
interface psb_bus_if;
  import psb_pkg::*;
  logic [AD_W-1:0] cpu_ad_o;
  logic cpu_ad_oe;
  logic [CMD_W-1:0] cpu_cmd_o;
  logic [CMD_W-1:0] cpu_cmd_oe;
  logic cpu_drives_valid_n;
  logic cpu_owns_bus_n;
  logic [AD_W-1:0] agt_ad_o;
  logic agt_ad_oe;
  logic [CMD_W-1:0] agt_cmd_o;
  logic [CMD_W-1:0] agt_cmd_oe;
  logic agent_drives_valid_n;
  logic agent_bus_request_n;
  logic agent_write_accept_n;
  logic agent_read_accept_n;
  logic legacy_bus_select;
  wire [AD_W-1:0] addr_data_bus;
  wire [CMD_W-1:0] cmd_ident_bus;
  // Wire level from the enables, processor first
  assign addr_data_bus = cpu_ad_oe ? cpu_ad_o : (agt_ad_oe ? agt_ad_o : AD_ZERO);
  assign cmd_ident_bus = (cpu_cmd_o & cpu_cmd_oe) | (agt_cmd_o & agt_cmd_oe & ~cpu_cmd_oe);
  modport cpu (
    output cpu_ad_o, cpu_ad_oe, cpu_cmd_o, cpu_cmd_oe, cpu_drives_valid_n, cpu_owns_bus_n,
    input addr_data_bus, cmd_ident_bus, agent_drives_valid_n, agent_bus_request_n,
    input agent_write_accept_n, agent_read_accept_n, legacy_bus_select
  );
  modport agent (
    output agt_ad_o, agt_ad_oe, agt_cmd_o, agt_cmd_oe, agent_drives_valid_n,
    output agent_bus_request_n, agent_write_accept_n, agent_read_accept_n,
    input addr_data_bus, cmd_ident_bus, cpu_drives_valid_n, cpu_owns_bus_n, legacy_bus_select
  );
endinterface : psb_bus_if
`default_nettype wire

/* src/psb_cpu_end.sv */
// Processor end of the system bus, with its synchroniser and FIFO
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser
module psb_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  // Runs through reset, so the strap is settled at release
  always_ff @(posedge core_clk)
  begin
    meta_r <= d;
    q <= meta_r;
  end
endmodule : psb_sync

// FIFO with registered flags
module psb_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_r];
  assign count_nxt = push && !pop ? count_r + CNT_ONE :
                     (!push && pop ? count_r - CNT_ONE : count_r);
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_ptr_r <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_r <= pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
      count_r <= count_nxt;
      in_ready <= count_nxt != CNT_FULL;
      out_valid <= count_nxt != '0;
    end
  end
endmodule : psb_fifo

// Overview of operation
// - Shared 32-bit multiplexed address/data bus
// - Extended mode: 9-bit command/identifier bus
// - Legacy mode: only low five command lines
// - Agent valid only with valid word driven
// - Processor valid only with valid word driven
// - Agent requests bus with active-low request
// - Extended: low pulse yields bus to agent
// - Legacy: same pin low while processor masters
// - Writes only while agent write-accept asserted
// - Extended: reads only while read-accept asserted
// - Strap low legacy, high extended mode
// - Legacy: drive zero on command lines 5-8
// - Legacy: read-accept reserved, held at zero
module psb_cpu_end
  import psb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  psb_bus_if.cpu bus,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic tx_is_read,
  input wire logic [CMD_W-1:0] tx_cmd,
  input wire logic [AD_W-1:0] tx_data,
  output logic rx_valid,
  output logic [CMD_W-1:0] rx_cmd,
  output logic [AD_W-1:0] rx_data,
  output logic legacy_mode,
  output logic owns_bus
);
  localparam int IN_W = AD_W + CMD_W + 5;
  psb_state_t state_r;
  psb_state_t state_nxt;
  logic [IN_W-1:0] in_s;
  logic strap_done_r;
  logic fifo_valid;
  logic [CPU_WORD_W-1:0] fifo_word;
  logic [CMD_W-1:0] cmd_o_r;
  logic [CMD_W-1:0] cmd_oe_r;
  logic [AD_W-1:0] ad_o_r;
  logic ad_oe_r;
  logic valid_n_r;
  logic owns_n_r;

  // Every pin from the agent passes two flops
  psb_sync #(.W(IN_W)) u_sync (
    .core_clk(core_clk),
    .d({bus.addr_data_bus, bus.cmd_ident_bus, bus.agent_drives_valid_n,
        bus.agent_bus_request_n, bus.agent_write_accept_n, bus.agent_read_accept_n,
        bus.legacy_bus_select}),
    .q(in_s)
  );

  wire [AD_W-1:0] ad_s = in_s[IN_W-1 -: AD_W];
  wire [CMD_W-1:0] cmd_s = in_s[IN_W-AD_W-1 -: CMD_W];
  wire avalid_s = in_s[4] == PIN_ASSERT;
  wire req_s = in_s[3] == PIN_ASSERT;
  wire wacc_s = in_s[2] == PIN_ASSERT;
  wire racc_s = in_s[1] == PIN_ASSERT;
  wire strap_s = in_s[0];
  wire is_legacy = legacy_mode == MODE_LEGACY;
  wire [CMD_W-1:0] cmd_mask = is_legacy ? CMD_OE_LEG : CMD_OE_ALL;
  wire word_rd = fifo_word[CPU_WORD_W-1];
  wire rd_ok = is_legacy ? wacc_s : racc_s;
  wire acc_ok = word_rd ? rd_ok : wacc_s;
  wire send_go = strap_done_r && state_r == PSB_ST_MASTER && !req_s && fifo_valid && acc_ok;
  wire [CMD_W-1:0] oe_idle = is_legacy ? CMD_GND_LEG : CMD_OE_NONE;

  psb_fifo #(.W(CPU_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data({tx_is_read, tx_cmd, tx_data}),
    .out_valid(fifo_valid),
    .out_ready(send_go),
    .out_data(fifo_word)
  );

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      PSB_ST_MASTER: if (strap_done_r && req_s && !send_go) state_nxt = PSB_ST_YIELD;
      PSB_ST_YIELD: state_nxt = PSB_ST_SLAVE;
      PSB_ST_SLAVE: if (!req_s) state_nxt = PSB_ST_MASTER;
      default: state_nxt = PSB_ST_MASTER;
    endcase
  end

  // Extended: one-cycle release; legacy: low while master
  wire owns_n_nxt = is_legacy ? (state_nxt == PSB_ST_MASTER ? PIN_ASSERT : PIN_IDLE) :
                    (state_nxt == PSB_ST_YIELD ? PIN_ASSERT : PIN_IDLE);
  wire drive_nxt = state_nxt == PSB_ST_MASTER;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= PSB_ST_MASTER;
      strap_done_r <= 1'b0;
      legacy_mode <= MODE_LEGACY;
      ad_o_r <= AD_ZERO;
      ad_oe_r <= 1'b0;
      cmd_o_r <= CMD_ZERO;
      cmd_oe_r <= CMD_OE_NONE;
      valid_n_r <= PIN_IDLE;
      owns_n_r <= PIN_IDLE;
      rx_valid <= 1'b0;
      rx_cmd <= CMD_ZERO;
      rx_data <= AD_ZERO;
      owns_bus <= 1'b0;
    end
    else
    begin
      strap_done_r <= 1'b1;
      if (!strap_done_r)
        legacy_mode <= strap_s;
      state_r <= state_nxt;
      ad_oe_r <= strap_done_r && drive_nxt;
      cmd_oe_r <= strap_done_r && drive_nxt ? cmd_mask | oe_idle : oe_idle;
      if (send_go)
      begin
        ad_o_r <= fifo_word[AD_W-1:0];
        cmd_o_r <= fifo_word[AD_W +: CMD_W] & cmd_mask;
      end
      valid_n_r <= send_go ? PIN_ASSERT : PIN_IDLE;
      owns_n_r <= strap_done_r ? owns_n_nxt : PIN_IDLE;
      owns_bus <= strap_done_r && drive_nxt;
      rx_valid <= state_r == PSB_ST_SLAVE && avalid_s;
      if (state_r == PSB_ST_SLAVE && avalid_s)
      begin
        rx_cmd <= cmd_s & cmd_mask;
        rx_data <= ad_s;
      end
    end
  end

  assign bus.cpu_ad_o = ad_o_r;
  assign bus.cpu_ad_oe = ad_oe_r;
  assign bus.cpu_cmd_o = cmd_o_r;
  assign bus.cpu_cmd_oe = cmd_oe_r;
  assign bus.cpu_drives_valid_n = valid_n_r;
  assign bus.cpu_owns_bus_n = owns_n_r;
endmodule : psb_cpu_end
`default_nettype wire

/* src/psb_agent_end.sv */
// External agent end of the system bus
`timescale 1ns/1ps
`default_nettype none
module psb_agent_end
  import psb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  psb_bus_if.agent bus,
  input wire logic want_bus,
  input wire logic can_write,
  input wire logic can_read,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [CMD_W-1:0] tx_cmd,
  input wire logic [AD_W-1:0] tx_data,
  output logic rx_valid,
  output logic [CMD_W-1:0] rx_cmd,
  output logic [AD_W-1:0] rx_data,
  output logic granted,
  output logic legacy_mode
);
  localparam int IN_W = AD_W + CMD_W + 3;
  logic [IN_W-1:0] in_s;
  logic strap_done_r;
  logic [AD_W-1:0] ad_o_r;
  logic ad_oe_r;
  logic [CMD_W-1:0] cmd_o_r;
  logic [CMD_W-1:0] cmd_oe_r;
  logic valid_n_r;
  logic req_n_r;
  logic wacc_n_r;
  logic racc_n_r;

  psb_sync #(.W(IN_W)) u_sync (
    .core_clk(core_clk),
    .d({bus.addr_data_bus, bus.cmd_ident_bus, bus.cpu_drives_valid_n,
        bus.cpu_owns_bus_n, bus.legacy_bus_select}),
    .q(in_s)
  );

  wire [AD_W-1:0] ad_s = in_s[IN_W-1 -: AD_W];
  wire [CMD_W-1:0] cmd_s = in_s[IN_W-AD_W-1 -: CMD_W];
  wire cvalid_s = in_s[2] == PIN_ASSERT;
  wire owns_pin_s = in_s[1];
  wire strap_s = in_s[0];
  wire is_legacy = legacy_mode == MODE_LEGACY;
  wire [CMD_W-1:0] cmd_mask = is_legacy ? CMD_OE_LEG : CMD_OE_ALL;
  // Grant: release pulse, or processor no longer master
  wire grant_seen = is_legacy ? owns_pin_s == PIN_IDLE : owns_pin_s == PIN_ASSERT;
  wire grant_nxt = strap_done_r && want_bus && req_n_r == PIN_ASSERT && (granted || grant_seen);
  wire send_go = tx_valid && tx_ready;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_done_r <= 1'b0;
      legacy_mode <= MODE_LEGACY;
      granted <= 1'b0;
      tx_ready <= 1'b0;
      ad_o_r <= AD_ZERO;
      ad_oe_r <= 1'b0;
      cmd_o_r <= CMD_ZERO;
      cmd_oe_r <= CMD_OE_NONE;
      valid_n_r <= PIN_IDLE;
      req_n_r <= PIN_IDLE;
      wacc_n_r <= PIN_IDLE;
      racc_n_r <= PIN_IDLE;
      rx_valid <= 1'b0;
      rx_cmd <= CMD_ZERO;
      rx_data <= AD_ZERO;
    end
    else
    begin
      strap_done_r <= 1'b1;
      if (!strap_done_r)
        legacy_mode <= strap_s;
      req_n_r <= strap_done_r && want_bus ? PIN_ASSERT : PIN_IDLE;
      granted <= grant_nxt;
      tx_ready <= grant_nxt;
      // Keep driving while a last word goes out
      ad_oe_r <= grant_nxt || send_go;
      cmd_oe_r <= grant_nxt || send_go ? cmd_mask : CMD_OE_NONE;
      if (send_go)
      begin
        ad_o_r <= tx_data;
        cmd_o_r <= tx_cmd & cmd_mask;
      end
      valid_n_r <= send_go ? PIN_ASSERT : PIN_IDLE;
      wacc_n_r <= strap_done_r && can_write ? PIN_ASSERT : PIN_IDLE;
      racc_n_r <= is_legacy || (strap_done_r && can_read) ? PIN_ASSERT : PIN_IDLE;
      rx_valid <= !granted && cvalid_s;
      if (!granted && cvalid_s)
      begin
        rx_cmd <= cmd_s & cmd_mask;
        rx_data <= ad_s;
      end
    end
  end

  assign bus.agt_ad_o = ad_o_r;
  assign bus.agt_ad_oe = ad_oe_r;
  assign bus.agt_cmd_o = cmd_o_r;
  assign bus.agt_cmd_oe = cmd_oe_r;
  assign bus.agent_drives_valid_n = valid_n_r;
  assign bus.agent_bus_request_n = req_n_r;
  assign bus.agent_write_accept_n = wacc_n_r;
  assign bus.agent_read_accept_n = racc_n_r;
endmodule : psb_agent_end
`default_nettype wire

/* sim/psb_bus_props.sv */
// Concurrent checks on the joining bus
`timescale 1ns/1ps
`default_nettype none
module psb_bus_props
  import psb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cpu_ad_oe,
  input wire logic [CMD_W-1:0] cpu_cmd_o,
  input wire logic [CMD_W-1:0] cpu_cmd_oe,
  input wire logic cpu_drives_valid_n,
  input wire logic cpu_owns_bus_n,
  input wire logic agt_ad_oe,
  input wire logic agent_drives_valid_n,
  input wire logic agent_write_accept_n,
  input wire logic agent_read_accept_n,
  input wire logic legacy_bus_select
);
  logic [2:0] up_cnt_r;
  logic up;
  logic leg;
  logic no_acc;
  assign up = (up_cnt_r == 3'h7);
  assign leg = up && (legacy_bus_select == MODE_LEGACY);
  assign no_acc = agent_write_accept_n && (agent_read_accept_n || !legacy_bus_select);
  // Settle time after reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      up_cnt_r <= 3'h0;
    else if (!up)
      up_cnt_r <= up_cnt_r + 3'h1;
  end
  default clocking dflt @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_cpu_valid;
    !cpu_drives_valid_n |-> cpu_ad_oe && (cpu_cmd_oe[4:0] == 5'h1f);
  endproperty
  a_cpu_valid: assert property (p_cpu_valid) else $error("cpu valid, bus not driven");
  property p_agt_valid;
    !agent_drives_valid_n |-> agt_ad_oe && !cpu_ad_oe;
  endproperty
  a_agt_valid: assert property (p_agt_valid) else $error("agent valid, bus not driven");
  property p_one_driver;
    !(cpu_ad_oe && agt_ad_oe);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("two bus drivers");
  property p_leg_gnd;
    leg |-> (cpu_cmd_o[8:5] == 4'h0) && (cpu_cmd_oe[8:5] == 4'hf);
  endproperty
  a_leg_gnd: assert property (p_leg_gnd) else $error("upper cmd lines not low");
  property p_rd_rsv;
    leg |-> !agent_read_accept_n;
  endproperty
  a_rd_rsv: assert property (p_rd_rsv) else $error("reserved read accept high");
  property p_no_accept;
    (up && no_acc)[*5] |-> cpu_drives_valid_n;
  endproperty
  a_no_accept: assert property (p_no_accept) else $error("word sent unaccepted");
  property p_ext_pulse;
    up && legacy_bus_select && $fell(cpu_owns_bus_n) |-> !cpu_ad_oe ##1 cpu_owns_bus_n;
  endproperty
  a_ext_pulse: assert property (p_ext_pulse) else $error("bad release pulse");
  property p_leg_master;
    leg |-> cpu_owns_bus_n == !cpu_ad_oe;
  endproperty
  a_leg_master: assert property (p_leg_master) else $error("master pin wrong");
endmodule : psb_bus_props
`default_nettype wire

/* sim/test_processor_system_bus_pins.sv */
// Self-checking bench joining both bus ends
`timescale 1ns/1ps
`default_nettype none
module test_processor_system_bus_pins
  import psb_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic c_tv, c_rd, c_tr, c_rv, c_lg, c_own, a_want, a_cw, a_cr, a_tv, a_tr, a_rv, a_gr, a_lg;
  logic [CMD_W-1:0] c_tc, c_rc, a_tc, a_rc;
  logic [AD_W-1:0] c_td, c_rdat, a_td, a_rdat;
  logic [AGT_WORD_W-1:0] q_agt[$];
  logic [AGT_WORD_W-1:0] q_cpu[$];
  logic [31:0] seed;
  logic mode;
  int n_errors, num_checks, low_cnt;
  psb_bus_if bus_if();
  psb_cpu_end psb_cpu_end_inst (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_if),
    .tx_valid(c_tv), .tx_ready(c_tr), .tx_is_read(c_rd), .tx_cmd(c_tc), .tx_data(c_td),
    .rx_valid(c_rv), .rx_cmd(c_rc), .rx_data(c_rdat), .legacy_mode(c_lg), .owns_bus(c_own));
  psb_agent_end psb_agent_end_inst (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_if),
    .want_bus(a_want), .can_write(a_cw), .can_read(a_cr), .tx_valid(a_tv), .tx_ready(a_tr),
    .tx_cmd(a_tc), .tx_data(a_td), .rx_valid(a_rv), .rx_cmd(a_rc), .rx_data(a_rdat),
    .granted(a_gr), .legacy_mode(a_lg));
  psb_bus_props psb_bus_props_inst (.core_clk(core_clk), .rst_n(rst_n),
    .cpu_ad_oe(bus_if.cpu_ad_oe), .cpu_cmd_o(bus_if.cpu_cmd_o), .cpu_cmd_oe(bus_if.cpu_cmd_oe),
    .cpu_drives_valid_n(bus_if.cpu_drives_valid_n), .cpu_owns_bus_n(bus_if.cpu_owns_bus_n),
    .agt_ad_oe(bus_if.agt_ad_oe), .agent_drives_valid_n(bus_if.agent_drives_valid_n),
    .agent_write_accept_n(bus_if.agent_write_accept_n),
    .agent_read_accept_n(bus_if.agent_read_accept_n),
    .legacy_bus_select(bus_if.legacy_bus_select));
  always #2.5 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (!ok)
    begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  function automatic logic cond(input int sel);
    case (sel)
      0: return q_agt.size() == 0 && q_cpu.size() == 0;
      1: return a_gr === 1'b1;
      default: return c_own === 1'b1;
    endcase
  endfunction : cond
  task automatic wait_until(input int sel, input int lim);
    int n;
    n = 0;
    while (!cond(sel) && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    check(cond(sel), "wait timed out");
    if (!cond(sel))
      close_out();
  endtask : wait_until
  // Offer one word and hold it until taken or the bound runs out
  task automatic push(input logic agt, input logic rd, input logic [31:0] s, input int lim,
    output logic ok);
    int n;
    n = 0;
    if (agt)
      a_tv <= 1'b1;
    else
      c_tv <= 1'b1;
    c_rd <= rd;
    c_tc <= s[8:0];
    a_tc <= s[8:0];
    c_td <= ~s;
    a_td <= ~s;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while ((agt ? a_tr : c_tr) !== 1'b1 && n < lim);
    ok = ((agt ? a_tr : c_tr) === 1'b1);
    @(posedge core_clk);
    if (ok && agt)
      q_cpu.push_back({s[8:5] & {4{mode}}, s[4:0], ~s});
    else if (ok)
      q_agt.push_back({s[8:5] & {4{mode}}, s[4:0], ~s});
  endtask : push
  always @(posedge core_clk)
  begin
    if (rst_n && bus_if.cpu_owns_bus_n === 1'b0)
      low_cnt++;
    if (rst_n && a_rv === 1'b1)
    begin
      check(q_agt.size() > 0 && {a_rc, a_rdat} === q_agt[0], "agent word");
      if (q_agt.size() > 0)
        void'(q_agt.pop_front());
    end
    if (rst_n && c_rv === 1'b1)
    begin
      check(q_cpu.size() > 0 && {c_rc, c_rdat} === q_cpu[0], "cpu word");
      if (q_cpu.size() > 0)
        void'(q_cpu.pop_front());
    end
  end
  task automatic run_mode(input logic m);
    logic ok;
    int k;
    mode = m;
    rst_n <= 1'b0;
    bus_if.legacy_bus_select <= m;
    a_cw <= 1'b1;
    a_cr <= 1'b1;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(c_lg === m && a_lg === m && c_own === 1'b1, "mode after reset");
    for (k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      push(1'b0, seed[20], seed, 20, ok);
      check(ok, "cpu word refused");
    end
    c_tv <= 1'b0;
    a_cw <= 1'b0;
    a_cr <= 1'b0;
    wait_until(0, 100);
    repeat (6) @(posedge core_clk);
    k = 0;
    ok = 1'b1;
    while (ok && k < 20)
    begin
      seed = lfsr(seed);
      push(1'b0, 1'b0, seed, 3, ok);
      k += int'(ok);
    end
    c_tv <= 1'b0;
    repeat (8) @(posedge core_clk);
    check(k == FIFO_DEPTH && q_agt.size() == FIFO_DEPTH, "fill or stall");
    a_cw <= 1'b1;
    wait_until(0, 200);
    if (m == MODE_EXTENDED)
    begin
      push(1'b0, 1'b1, 32'h1234_abcd, 20, ok);
      c_tv <= 1'b0;
      repeat (10) @(posedge core_clk);
      check(q_agt.size() == 1, "read sent early");
      a_cr <= 1'b1;
      wait_until(0, 50);
    end
    low_cnt = 0;
    a_want <= 1'b1;
    wait_until(1, 30);
    check(bus_if.cpu_owns_bus_n === 1'b1 && (!m || low_cnt == 1), "handover pin");
    for (k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      push(1'b1, 1'b0, seed, 5, ok);
      check(ok, "agent word refused");
    end
    a_tv <= 1'b0;
    wait_until(0, 50);
    a_want <= 1'b0;
    wait_until(2, 30);
  endtask : run_mode
  initial
  begin
    {c_tv, c_rd, a_want, a_cw, a_cr, a_tv, c_tc, a_tc, c_td, a_td} = '0;
    bus_if.legacy_bus_select = MODE_EXTENDED;
    seed = 32'hc7b8;
    n_errors = 0;
    num_checks = 0;
    low_cnt = 0;
    @(posedge core_clk);
    run_mode(MODE_EXTENDED);
    run_mode(MODE_LEGACY);
    close_out();
  end
endmodule : test_processor_system_bus_pins
`default_nettype wire
